/* File: rtl/sim_ctrl.sv */
// flush/wake pin handling and per-channel mode selection
`timescale 1ns/10ps
module sim_ctrl #(
  parameter int unsigned WAKE_CYCLES = sim_pkg::WAKE_CYCLES
) (
  // clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_reset_n,
  // flush/wake pin and its pull-down option
  input  wire logic                i_flush_wake_n,
  input  wire logic                i_pulldown_en,
  input  wire logic                i_suspended,
  // configuration memory
  input  wire logic                i_cfg_valid,
  input  wire sim_pkg::sim_cfg_t   i_cfg,
  // host side
  input  wire logic                i_enumerated,
  input  wire sim_pkg::sim_cmd_t   i_cmd,
  input  wire logic                i_chan_b_used,
  // mode outputs
  output sim_pkg::sim_mode_t       o_mode_a,
  output sim_pkg::sim_mode_t       o_mode_b,
  output logic                     o_cmd_rejected,
  output logic                     o_a_owns_b_buffer,
  // flush/wake events
  output logic                     o_send_now,
  output logic                     o_transfer_mark,
  output logic                     o_wake_req,
  // channel b pins
  output sim_pkg::sim_pins_t       o_pins_b
);

  // wake length must stay above the flush length
  if (WAKE_CYCLES <= sim_pkg::FLUSH_CYCLES) begin : g_bad_wake
    $error("wake length must exceed flush length");
  end

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= i_flush_wake_n;
      pin_sync <= pin_meta;
    end
  end

  // ------------------------------------------------------------
  // mode helpers
  // ------------------------------------------------------------
  function automatic logic pin_mode(input sim_pkg::sim_mode_t m);
    pin_mode = (m == sim_pkg::SIM_MODE_ASYNC_FIFO) || (m == sim_pkg::SIM_MODE_SYNC_FIFO) ||
               (m == sim_pkg::SIM_MODE_CPU_FIFO) || (m == sim_pkg::SIM_MODE_ASYNC_BB) ||
               (m == sim_pkg::SIM_MODE_SYNC_BB);
  endfunction

  function automatic logic cfg_mode_ok(input logic [3:0] m);
    cfg_mode_ok = (m == sim_pkg::SIM_MODE_UART) || (m == sim_pkg::SIM_MODE_ASYNC_FIFO) ||
                  (m == sim_pkg::SIM_MODE_CPU_FIFO) || (m == sim_pkg::SIM_MODE_FAST_SER);
  endfunction

  logic pin_enable;
  assign pin_enable = pin_mode(o_mode_a);

  // ------------------------------------------------------------
  // pulse measurement
  // ------------------------------------------------------------
  logic ev_fall;
  logic ev_short;
  logic ev_long;

  sim_pulse_meter #(
    .SHORT_CYCLES (sim_pkg::FLUSH_CYCLES),
    .LONG_CYCLES  (WAKE_CYCLES)
  ) u_meter (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_pin     (pin_sync),
    .i_enable  (pin_enable),
    .o_fall    (ev_fall),
    .o_short   (ev_short),
    .o_long    (ev_long)
  );

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_transfer_mark <= 1'b0;
      o_send_now      <= 1'b0;
      o_wake_req      <= 1'b0;
    end else begin
      o_transfer_mark <= ev_fall;
      o_send_now      <= ev_short;
      o_wake_req      <= ev_long && i_suspended && !i_pulldown_en;
    end
  end

  // ------------------------------------------------------------
  // mode selection
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SIM_ST_RESET  = 2'b00,
    SIM_ST_CONFIG = 2'b01,
    SIM_ST_RUN    = 2'b10
  } sim_state_t;

  sim_state_t         state;
  sim_pkg::sim_mode_t base_a;
  sim_pkg::sim_mode_t base_b;
  sim_pkg::sim_mode_t next_mode;
  logic               next_ok;
  sim_pkg::sim_mode_t cur;
  sim_pkg::sim_mode_t base;

  always_comb begin
    cur  = i_cmd.chan_b ? o_mode_b : o_mode_a;
    base = i_cmd.chan_b ? base_b : base_a;
    next_mode = cur;
    next_ok   = 1'b1;
    case (i_cmd.value)
      sim_pkg::CMD_RESET: begin
        next_mode = base;
      end
      sim_pkg::CMD_ASYNC_BB: begin
        next_mode = sim_pkg::SIM_MODE_ASYNC_BB;
      end
      sim_pkg::CMD_SYNC_BB: begin
        next_mode = sim_pkg::SIM_MODE_SYNC_BB;
      end
      sim_pkg::CMD_SERIAL_ENG: begin
        next_mode = sim_pkg::SIM_MODE_SERIAL_ENG;
      end
      sim_pkg::CMD_HOST_BUS: begin
        next_mode = sim_pkg::SIM_MODE_HOST_BUS;
      end
      sim_pkg::CMD_SYNC_FIFO: begin
        next_mode = sim_pkg::SIM_MODE_SYNC_FIFO;
        next_ok   = !i_cmd.chan_b && base_a == sim_pkg::SIM_MODE_ASYNC_FIFO &&
                    base_b == sim_pkg::SIM_MODE_ASYNC_FIFO;
      end
      default: begin
        next_ok = 1'b0;
      end
    endcase
    if (o_mode_a == sim_pkg::SIM_MODE_SYNC_FIFO && i_cmd.chan_b) begin
      next_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state          <= SIM_ST_RESET;
      o_mode_a       <= sim_pkg::RESET_MODE;
      o_mode_b       <= sim_pkg::RESET_MODE;
      base_a         <= sim_pkg::RESET_MODE;
      base_b         <= sim_pkg::RESET_MODE;
      o_cmd_rejected <= 1'b0;
    end else begin
      o_cmd_rejected <= 1'b0;
      case (state)
        SIM_ST_RESET: begin
          state <= SIM_ST_CONFIG;
        end
        SIM_ST_CONFIG: begin
          if (i_cfg_valid) begin
            if (cfg_mode_ok(i_cfg.mode_a)) begin
              base_a   <= sim_pkg::sim_mode_t'(i_cfg.mode_a);
              o_mode_a <= sim_pkg::sim_mode_t'(i_cfg.mode_a);
            end
            if (cfg_mode_ok(i_cfg.mode_b)) begin
              base_b   <= sim_pkg::sim_mode_t'(i_cfg.mode_b);
              o_mode_b <= sim_pkg::sim_mode_t'(i_cfg.mode_b);
            end
            state <= SIM_ST_RUN;
          end
        end
        SIM_ST_RUN: begin
          if (i_cmd.valid) begin
            if (!i_enumerated || !next_ok) begin
              o_cmd_rejected <= 1'b1;
            end else if (i_cmd.chan_b) begin
              o_mode_b <= next_mode;
            end else begin
              o_mode_a <= next_mode;
              if (next_mode == sim_pkg::SIM_MODE_SYNC_FIFO) begin
                o_mode_b <= sim_pkg::SIM_MODE_UNAVAIL;
              end else if (o_mode_a == sim_pkg::SIM_MODE_SYNC_FIFO) begin
                o_mode_b <= base_b;
              end
            end
          end
        end
        default: begin
          state <= SIM_ST_RESET;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // buffer ownership and channel b pins
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_a_owns_b_buffer <= 1'b0;
      o_pins_b          <= '{data_oe_n: 8'hff, tx_space_n: 1'b0, rx_avail_n: 1'b1, strobes_are_inputs: 1'b1};
    end else begin
      o_a_owns_b_buffer <= (o_mode_a == sim_pkg::SIM_MODE_SYNC_FIFO);
      if (o_mode_b == sim_pkg::SIM_MODE_UNAVAIL && !i_chan_b_used) begin
        o_pins_b <= '{data_oe_n: 8'hff, tx_space_n: 1'b0, rx_avail_n: 1'b1, strobes_are_inputs: 1'b1};
      end
    end
  end

endmodule

/* File: rtl/sim_pkg.sv */
// package: constants and types for flush/wake and channel mode control
package sim_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned FLUSH_PULSE_NS = 250;
  localparam int unsigned WAKE_PULSE_MS  = 20;
  // least times round up
  localparam int unsigned FLUSH_CYCLES  = (FLUSH_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WAKE_CYCLES   = WAKE_PULSE_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------
  // host mode command values
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_RESET      = 8'h00;
  localparam logic [7:0] CMD_ASYNC_BB   = 8'h01;
  localparam logic [7:0] CMD_SERIAL_ENG = 8'h02;
  localparam logic [7:0] CMD_SYNC_BB    = 8'h04;
  localparam logic [7:0] CMD_HOST_BUS   = 8'h08;
  localparam logic [7:0] CMD_SYNC_FIFO  = 8'h40;

  // ------------------------------------------------------------
  // channel modes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SIM_MODE_UART       = 4'h0,
    SIM_MODE_ASYNC_FIFO = 4'h1,
    SIM_MODE_SYNC_FIFO  = 4'h2,
    SIM_MODE_CPU_FIFO   = 4'h3,
    SIM_MODE_FAST_SER   = 4'h4,
    SIM_MODE_ASYNC_BB   = 4'h5,
    SIM_MODE_SYNC_BB    = 4'h6,
    SIM_MODE_SERIAL_ENG = 4'h7,
    SIM_MODE_HOST_BUS   = 4'h8,
    SIM_MODE_UNAVAIL    = 4'h9
  } sim_mode_t;

  localparam sim_mode_t RESET_MODE = SIM_MODE_UART;

  // config memory contents, one mode per channel
  typedef struct packed {
    logic [3:0] mode_a;
    logic [3:0] mode_b;
  } sim_cfg_t;

  // host mode-select command
  typedef struct packed {
    logic       valid;
    logic       chan_b;
    logic [7:0] value;
  } sim_cmd_t;

  // channel b parallel pin defaults
  typedef struct packed {
    logic [7:0] data_oe_n;
    logic       tx_space_n;
    logic       rx_avail_n;
    logic       strobes_are_inputs;
  } sim_pins_t;

endpackage

/* File: rtl/sim_pulse_meter.sv */
// low pulse width meter for the flush/wake pin
`timescale 1ns/10ps
module sim_pulse_meter #(
  parameter int unsigned SHORT_CYCLES = 10,
  parameter int unsigned LONG_CYCLES  = 800_000
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  // synchronised pin level and enable
  input  wire logic i_pin,
  input  wire logic i_enable,
  // events
  output logic      o_fall,
  output logic      o_short,
  output logic      o_long
);
  localparam int W = $clog2(LONG_CYCLES + 1);

  // thresholds the counter cannot serve
  if (SHORT_CYCLES < 1 || LONG_CYCLES <= SHORT_CYCLES) begin : g_bad_thresholds
    $error("bad pulse thresholds");
  end

  logic         prev;
  logic [W-1:0] count;
  logic         long_seen;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev <= 1'b1;
    end else begin
      prev <= i_pin;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count     <= '0;
      long_seen <= 1'b0;
      o_fall    <= 1'b0;
      o_short   <= 1'b0;
      o_long    <= 1'b0;
    end else begin
      o_fall  <= i_enable && prev && !i_pin;
      o_short <= 1'b0;
      o_long  <= 1'b0;
      if (!i_pin && i_enable) begin
        if (count != W'(LONG_CYCLES)) begin
          count <= count + W'(1);
        end
        if (count == W'(LONG_CYCLES - 1) && !long_seen) begin
          o_long    <= 1'b1;
          long_seen <= 1'b1;
        end
      end else begin
        if (!prev && i_pin && !long_seen && count >= W'(SHORT_CYCLES)) begin
          o_short <= i_enable;
        end
        count     <= '0;
        long_seen <= 1'b0;
      end
    end
  end
endmodule

/* File: verification/sim_ctrl_monitor.sv */
// checker: flush/wake timing and mode switching at the control block ports
`timescale 1ns/10ps
module sim_ctrl_monitor #(
  parameter int unsigned WAKE_CYCLES = sim_pkg::WAKE_CYCLES
) (
  // clock, reset, pin
  input wire logic               i_clk_sys,
  input wire logic               i_reset_n,
  input wire logic               i_flush_wake_n,
  input wire logic               i_pulldown_en,
  input wire logic               i_suspended,
  // config and host
  input wire logic               i_cfg_valid,
  input wire sim_pkg::sim_cfg_t  i_cfg,
  input wire logic               i_enumerated,
  input wire sim_pkg::sim_cmd_t  i_cmd,
  input wire logic               i_chan_b_used,
  // outputs watched
  input wire sim_pkg::sim_mode_t o_mode_a,
  input wire sim_pkg::sim_mode_t o_mode_b,
  input wire logic               o_cmd_rejected,
  input wire logic               o_a_owns_b_buffer,
  input wire logic               o_send_now,
  input wire logic               o_transfer_mark,
  input wire logic               o_wake_req,
  input wire sim_pkg::sim_pins_t o_pins_b
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  int unsigned low_cnt;
  int unsigned low_len;
  logic        act;
  logic        take;
  // ------------------------------------------------------------
  // low width helpers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) low_cnt <= 0;
    else if (i_flush_wake_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) low_len <= 0;
    else if (i_flush_wake_n && low_cnt != 0) low_len <= low_cnt;
  end
  assign act  = o_mode_a inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
  assign take = i_cmd.valid && i_enumerated && !i_cmd.chan_b;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence sync_taken;
    take && i_cmd.value == 8'h40 && o_mode_a == 4'h1 && o_mode_b == 4'h1;
  endsequence
  sequence sync_done;
    ##1 (o_mode_a == 4'h2 && o_mode_b == 4'h9) ##1 o_a_owns_b_buffer;
  endsequence
  reset_uart_a: assert property ($rose(i_reset_n) |-> o_mode_a == 4'h0 && o_mode_b == 4'h0)
    else $error("modes not serial after reset");
  mark_edge_a: assert property ($fell(i_flush_wake_n) && act |-> ##4 o_transfer_mark)
    else $error("transfer mark missing after pin fall");
  pin_gate_a: assert property (o_send_now || o_transfer_mark |-> act)
    else $error("pin event outside fifo or bit-bang mode");
  send_len_a: assert property (o_send_now |-> $past(i_flush_wake_n, 4) && low_len >= 10 && low_len < WAKE_CYCLES)
    else $error("send now on wrong pulse");
  wake_len_a: assert property (o_wake_req |-> !i_flush_wake_n && low_cnt >= WAKE_CYCLES && i_suspended && !i_pulldown_en)
    else $error("wake request without long low");
  unenum_rej_a: assert property (i_cmd.valid && !i_enumerated |=> o_cmd_rejected)
    else $error("command accepted before enumeration");
  sync_switch_a: assert property (sync_taken |-> sync_done)
    else $error("sync fifo switch wrong");
  sync_refuse_a: assert property (take && i_cmd.value == 8'h40 && o_mode_b == 4'h0 |=> o_cmd_rejected)
    else $error("sync fifo accepted without fifo pair");
  bitbang_sel_a: assert property (take && i_cmd.value == 8'h04 |=> o_mode_a == 4'h6)
    else $error("sync bit-bang not selected");
  pins_dflt_a: assert property (o_a_owns_b_buffer && !i_chan_b_used |-> o_pins_b == 11'h7fb)
    else $error("channel b pins not at defaults");
endmodule
bind sim_ctrl sim_ctrl_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_mon (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_flush_wake_n(i_flush_wake_n),
  .i_pulldown_en(i_pulldown_en), .i_suspended(i_suspended), .i_cfg_valid(i_cfg_valid),
  .i_cfg(i_cfg), .i_enumerated(i_enumerated), .i_cmd(i_cmd), .i_chan_b_used(i_chan_b_used),
  .o_mode_a(o_mode_a), .o_mode_b(o_mode_b), .o_cmd_rejected(o_cmd_rejected),
  .o_a_owns_b_buffer(o_a_owns_b_buffer), .o_send_now(o_send_now),
  .o_transfer_mark(o_transfer_mark), .o_wake_req(o_wake_req), .o_pins_b(o_pins_b));

/* File: verification/sim_host_model.sv */
// host model: driver mode commands
`timescale 1ns/10ps
module sim_host_model (
  // clock
  input  wire logic         i_clk_sys,
  // command and enumeration
  output sim_pkg::sim_cmd_t o_cmd,
  output logic              o_enumerated
);
  initial begin
    o_cmd = 10'h000;
    o_enumerated = 1'b0;
  end
  // one-cycle command, then inverted idle value
  task automatic send(input logic b, input logic [7:0] v);
    @(negedge i_clk_sys);
    o_cmd = {1'b1, b, v};
    @(negedge i_clk_sys);
    o_cmd = {1'b0, ~b, ~v};
  endtask
endmodule

/* File: verification/testbench.sv */
// testbench: flush/wake pulses and channel mode commands
`timescale 1ns/10ps
module testbench;
  logic               clk;
  logic               rst_n;
  logic               pin_n;
  logic               pd_en;
  logic               susp;
  logic               cfg_vld;
  logic [7:0]         cfg;
  logic               enum_q;
  sim_pkg::sim_cmd_t  cmd;
  sim_pkg::sim_mode_t mode_a;
  sim_pkg::sim_mode_t mode_b;
  sim_pkg::sim_pins_t pins;
  logic               rej;
  logic               owns;
  logic               send;
  logic               mark;
  logic               wake;
  int                 bad_count;
  int                 compares;
  int                 n_send;
  int                 n_mark;
  int                 n_wake;
  int                 n_rej;
  sim_host_model host (.i_clk_sys(clk), .o_cmd(cmd), .o_enumerated(enum_q));
  sim_ctrl #(.WAKE_CYCLES(40)) dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_flush_wake_n(pin_n), .i_pulldown_en(pd_en),
    .i_suspended(susp), .i_cfg_valid(cfg_vld), .i_cfg(cfg), .i_enumerated(enum_q), .i_cmd(cmd),
    .i_chan_b_used(1'b0), .o_mode_a(mode_a), .o_mode_b(mode_b), .o_cmd_rejected(rej),
    .o_a_owns_b_buffer(owns), .o_send_now(send), .o_transfer_mark(mark), .o_wake_req(wake),
    .o_pins_b(pins));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (send === 1'b1) n_send++;
    if (mark === 1'b1) n_mark++;
    if (wake === 1'b1) n_wake++;
    if (rej === 1'b1) n_rej++;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic boot(input logic [7:0] c, input logic [7:0] e);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("reset mode", 16'h0000, {mode_a, mode_b});
    repeat (2) @(negedge clk);
    cfg = c;
    cfg_vld = 1'b1;
    @(negedge clk);
    cfg_vld = 1'b0;
    @(negedge clk);
    chk("config mode", e, {mode_a, mode_b});
  endtask
  task automatic pulse(input int len, input int es, input int em, input int ew);
    n_send = 0;
    n_mark = 0;
    n_wake = 0;
    pin_n = 1'b0;
    repeat (len) @(negedge clk);
    pin_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("send now", es, n_send);
    chk("mark", em, n_mark);
    chk("wake", ew, n_wake);
  endtask
  task automatic cmd_chk(input logic b, input logic [7:0] v, input logic [7:0] em, input int er);
    n_rej = 0;
    host.send(b, v);
    repeat (2) @(negedge clk);
    chk("modes", em, {mode_a, mode_b});
    chk("rejected", er, n_rej);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_gate;
    boot(8'h00, 8'h00);
    pulse(12, 0, 0, 0);
    boot(8'h48, 8'h40);
    pulse(10, 0, 0, 0);
    boot(8'h33, 8'h33);
    pulse(10, 1, 1, 0);
  endtask
  task automatic test_flush_wake;
    boot(8'h11, 8'h11);
    pulse(10, 1, 1, 0);
    pulse(9, 0, 1, 0);
    pulse(50, 0, 1, 0);
    susp = 1'b1;
    pulse(50, 0, 1, 1);
    pd_en = 1'b1;
    pulse(50, 0, 1, 0);
    {pd_en, susp} = 2'b00;
  endtask
  task automatic test_sync_fifo;
    cmd_chk(1'b0, 8'h01, 8'h11, 1);
    host.o_enumerated = 1'b1;
    cmd_chk(1'b0, 8'h40, 8'h29, 0);
    chk("owns", 16'h0001, owns);
    chk("pins b", 16'h07fb, pins);
    pulse(10, 1, 1, 0);
    cmd_chk(1'b1, 8'h01, 8'h29, 1);
    cmd_chk(1'b0, 8'h00, 8'h11, 0);
    chk("owns", 16'h0000, owns);
  endtask
  task automatic test_host_modes;
    cmd_chk(1'b0, 8'h01, 8'h51, 0);
    pulse(10, 1, 1, 0);
    cmd_chk(1'b0, 8'h04, 8'h61, 0);
    cmd_chk(1'b1, 8'h02, 8'h67, 0);
    cmd_chk(1'b0, 8'h08, 8'h87, 0);
    cmd_chk(1'b0, 8'h33, 8'h87, 1);
  endtask
  task automatic test_sync_refuse;
    boot(8'h10, 8'h10);
    cmd_chk(1'b0, 8'h40, 8'h10, 1);
  endtask
  initial begin
    bad_count = 0;
    compares = 0;
    {rst_n, pin_n, pd_en, susp, cfg_vld, cfg} = {2'b01, 3'b000, 8'h00};
    test_gate;
    test_flush_wake;
    test_sync_fifo;
    test_host_modes;
    test_sync_refuse;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end
endmodule
